//--- ssp_pkg.sv
/*
 * constants shared by the subsystem id preload block: window and config
 * offsets, field positions, reset values and fixed config words.
 * assumes a single clock and synchronous resets.
 */
package ssp_pkg;
	// ==========================================
	// register and memory window offsets
	localparam logic [11:0] WIN_ECHO_LO   = 12'h300;
	localparam logic [11:0] WIN_ECHO_HI   = 12'h340;
	localparam logic [11:0] WIN_RO_COPY   = 12'h32c;
	localparam logic [11:0] WIN_PWR_CS    = 12'h344;
	localparam logic [11:0] WIN_GUARD     = 12'h3e0;
	localparam logic [11:0] WIN_PRELOAD   = 12'h3fc;
	localparam logic [15:0] MEM_RAM_TOP   = 16'h0400;
	// ==========================================
	// config space offsets
	localparam logic [7:0] CFG_IDS     = 8'h00;
	localparam logic [7:0] CFG_CMD     = 8'h04;
	localparam logic [7:0] CFG_CLASS   = 8'h08;
	localparam logic [7:0] CFG_LAT     = 8'h0c;
	localparam logic [7:0] CFG_BAR0    = 8'h10;
	localparam logic [7:0] CFG_BAR1    = 8'h14;
	localparam logic [7:0] CFG_SUBSYS  = 8'h2c;
	localparam logic [7:0] CFG_CAPPTR  = 8'h34;
	localparam logic [7:0] CFG_INT     = 8'h3c;
	localparam logic [7:0] CFG_PMC     = 8'h40;
	localparam logic [7:0] CFG_PWR_CS  = 8'h44;
	localparam logic [7:0] CFG_GUARD   = 8'he0;
	localparam logic [7:0] CFG_VEND_LO = 8'he4;
	localparam logic [7:0] CFG_PRELOAD = 8'hfc;
	// ==========================================
	// field positions
	localparam int VENDOR_LSB  = 0;
	localparam int DEVICE_LSB  = 16;
	localparam int PME_EN_BIT  = 8;
	localparam int LAT_LSB     = 11;
	// ==========================================
	// reset values and fixed words
	localparam logic [31:0] PRELOAD_RST = 32'h0000_0000;
	localparam logic [15:0] GUARD_RST   = 16'h0000;
	localparam logic [15:0] STATUS_WORD = 16'h0210;
	localparam logic [23:0] CLASS_CODE  = 24'h040100;
	localparam logic [7:0]  REVISION    = 8'h01;
	localparam logic [7:0]  CAP_PTR     = 8'h40;
	localparam logic [7:0]  CAP_ID_PM   = 8'h01;
	localparam logic [15:0] PMC_WORD    = 16'h7e22;
	localparam logic [7:0]  MAX_LAT     = 8'h18;
	localparam logic [7:0]  MIN_GNT     = 8'h04;
	localparam logic [7:0]  INT_PIN     = 8'h01;
	localparam logic [7:0]  EE_MARKER   = 8'h55;
	localparam logic [3:0]  EE_LAST_IDX = 4'h4;

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction
endpackage

//--- ssp_regs_if.sv
/*
 * register state handed from the block top to its config view decoders.
 * assumes the top drives every signal from its state register.
 */
interface ssp_regs_if;
	logic [31:0] preload;
	logic [15:0] guard;
	logic        pme_en;
	logic [1:0]  power_state;
	logic        mem_en;
	logic        master_en;
	logic [4:0]  lat_timer;
	logic [19:0] bar0_base;
	logic [15:0] bar1_base;
	logic [7:0]  int_line;

	modport owner (output preload, guard, pme_en, power_state, mem_en, master_en,
		lat_timer, bar0_base, bar1_base, int_line);
	modport reader (input preload, guard, pme_en, power_state, mem_en, master_en,
		lat_timer, bar0_base, bar1_base, int_line);
endinterface

//--- ssp_cfg_view.sv
/*
 * read decoder of the config space dword at a given offset.
 * assumes a dword-aligned offset; purely combinational.
 */
module ssp_cfg_view
	import ssp_pkg::*;
#(
	parameter logic [15:0] VENDOR_CODE = 16'h0f0f,
	parameter logic [15:0] DEVICE_CODE = 16'h0e0e
) (
	ssp_regs_if.reader regs,
	input  wire logic [7:0]  ofs,
	output logic      [31:0] data
);
	// ==========================================
	// dword read mux
	always_comb begin
		case (ofs)
			CFG_IDS:     data = {DEVICE_CODE, VENDOR_CODE};
			CFG_CMD:     data = {STATUS_WORD, 13'h0, regs.master_en, regs.mem_en, 1'b0};
			CFG_CLASS:   data = {CLASS_CODE, REVISION};
			CFG_LAT:     data = {16'h0, regs.lat_timer, 3'h0, 8'h00};
			CFG_BAR0:    data = {regs.bar0_base, 12'h000};
			CFG_BAR1:    data = {regs.bar1_base, 16'h0000};
			CFG_SUBSYS:  data = regs.preload;  // see RULE_04
			CFG_CAPPTR:  data = {24'h0, CAP_PTR};
			CFG_INT:     data = {MAX_LAT, MIN_GNT, INT_PIN, regs.int_line};
			CFG_PMC:     data = {PMC_WORD, 8'h00, CAP_ID_PM};
			CFG_PWR_CS:  data = {23'h0, regs.pme_en, 6'h0, regs.power_state};
			CFG_GUARD:   data = {16'h0, regs.guard};
			CFG_PRELOAD: data = regs.preload;
			default:     data = 32'h0000_0000;
		endcase
	end
endmodule

//--- ssp_ee_loader.sv
/*
 * gathers the preload word from the serial eeprom byte stream.
 * assumes an eeprom reader on the same clock presents one byte per
 * valid pulse, starting with byte 0 after a start pulse.
 */
module ssp_ee_loader
	import ssp_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        ee_start,
	input  wire logic        ee_byte_valid,
	input  wire logic [7:0]  ee_byte,
	output logic             load,
	output logic      [31:0] word
);
	typedef struct packed {
		logic [3:0]  idx;
		logic        armed;
		logic        load;
		logic [31:0] word;
	} ssp_ee_state_t;

	ssp_ee_state_t r;
	ssp_ee_state_t next_r;

	// ==========================================
	// byte collector
	always_comb begin
		next_r = r;
		next_r.load = 1'b0;
		if (ee_start) begin
			next_r.idx = 4'h0;
			next_r.armed = 1'b0;
		end else if (ee_byte_valid && r.idx <= EE_LAST_IDX) begin
			if (r.idx == 4'h0) begin
				next_r.armed = (ee_byte == EE_MARKER);  // see RULE_18
			end else begin
				next_r.word = {ee_byte, r.word[31:8]};  // byte 1 lands lowest
			end
			next_r.idx = r.idx + 4'h1;
			next_r.load = r.armed && (r.idx == EE_LAST_IDX);  // see RULE_09
		end
		if (reset) begin
			next_r = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		r <= next_r;
	end

	assign load = r.load;
	assign word = r.word;
endmodule

//--- ssp_top.sv
/*
 * subsystem id preload register bank: register window, memory window and
 * config space target logic, with eeprom preload.
 * assumes a bus front end on ref_clk that presents one decoded data phase
 * per request pulse; reset and aux_reset are synchronous, active high.
 */
// Overview of operation
// RULE_01: vendor id held in bits 15 to 0
// RULE_02: device id held in bits 31 to 16
// RULE_03: config fch write needs guard key
// RULE_04: config 2ch reads preload, ignores writes
// RULE_05: window 3fch writes preload, never gated
// RULE_06: window 32ch shows read-only preload copy
// RULE_07: core reset leaves preload untouched
// RULE_08: aux reset clears preload to zero
// RULE_09: eeprom contents load the preload
// RULE_10: core registers cleared by core reset
// RULE_11: aux registers cleared by aux reset only
// RULE_12: window registers read-write unless marked
// RULE_13: window 300h-340h echoes config read-only
// RULE_14: guard register reachable at window 3e0h
// RULE_15: power control/status at window 344h, aux
// RULE_16: decode register and memory regions
// RULE_17: config e4h-ffh writable only with key
// RULE_18: marker 55h copies eeprom bytes 1-4
// RULE_19: config accesses honour byte enables
// RULE_20: host write beats eeprom load
module ssp_top
	import ssp_pkg::*;
#(
	parameter logic [15:0] UNLOCK_KEY  = 16'h5a5a,  // arbitrary value
	parameter logic [15:0] VENDOR_CODE = 16'h0f0f,  // arbitrary value
	parameter logic [15:0] DEVICE_CODE = 16'h0e0e,  // arbitrary value
	parameter int          RAM_WORDS   = 256
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        aux_reset,
	input  wire logic        win_req,
	input  wire logic        win_write,
	input  wire logic [31:0] win_addr,
	input  wire logic [3:0]  win_be,
	input  wire logic [31:0] win_wdata,
	output logic      [31:0] win_rdata,
	output logic             win_ack,
	output logic             win_hit,
	input  wire logic        cfg_req,
	input  wire logic        cfg_write,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata,
	output logic             cfg_ack,
	input  wire logic        ee_start,
	input  wire logic        ee_byte_valid,
	input  wire logic [7:0]  ee_byte,
	output logic      [31:0] subsys_ids,
	output logic             guard_open
);
	// ==========================================
	// state record, split by power domain
	typedef struct packed {
		// core powered
		logic        mem_en;
		logic        master_en;
		logic [4:0]  lat_timer;
		logic [19:0] bar0_base;
		logic [15:0] bar1_base;
		logic [7:0]  int_line;
		logic [31:0] win_rdata;
		logic        win_ack;
		logic        win_hit;
		logic [31:0] cfg_rdata;
		logic        cfg_ack;
		// aux powered
		logic [31:0] preload;
		logic [15:0] guard;
		logic        pme_en;
		logic [1:0]  power_state;
		logic        guard_open;
	} ssp_state_t;

	// index width of the memory window ram
	localparam int RAM_AW = $clog2(RAM_WORDS);

	ssp_state_t        r;
	ssp_state_t        next_r;
	logic [31:0]       ram [RAM_WORDS];
	logic [31:0]       cfg_view_data;
	logic [31:0]       echo_data;
	logic              ee_load;
	logic [31:0]       ee_word;
	logic              hit_regs;
	logic              hit_mem;
	logic [11:0]       reg_ofs;
	logic [15:0]       mem_ofs;
	logic [7:0]        cfg_dw;
	logic              vend_area;
	logic              ram_we;

	// ==========================================
	// helpers
	// word index of a memory window byte offset
	function automatic logic [RAM_AW-1:0] ram_index(input logic [15:0] ofs);
		return ofs[RAM_AW+1:2];
	endfunction

	ssp_regs_if regs_if ();

	// ==========================================
	// state handed to the config decoders
	assign regs_if.preload     = r.preload;
	assign regs_if.guard       = r.guard;
	assign regs_if.pme_en      = r.pme_en;
	assign regs_if.power_state = r.power_state;
	assign regs_if.mem_en      = r.mem_en;
	assign regs_if.master_en   = r.master_en;
	assign regs_if.lat_timer   = r.lat_timer;
	assign regs_if.bar0_base   = r.bar0_base;
	assign regs_if.bar1_base   = r.bar1_base;
	assign regs_if.int_line    = r.int_line;

	// ==========================================
	// decoders and eeprom collector
	ssp_cfg_view #(
		.VENDOR_CODE (VENDOR_CODE),
		.DEVICE_CODE (DEVICE_CODE)
	) u_cfg_view (
		.regs (regs_if.reader),
		.ofs  (cfg_dw),
		.data (cfg_view_data)
	);

	ssp_cfg_view #(
		.VENDOR_CODE (VENDOR_CODE),
		.DEVICE_CODE (DEVICE_CODE)
	) u_echo_view (
		.regs (regs_if.reader),
		.ofs  ({reg_ofs[7:2], 2'b00}),
		.data (echo_data)
	);

	ssp_ee_loader u_ee (
		.ref_clk       (ref_clk),
		.reset         (reset),
		.ee_start      (ee_start),
		.ee_byte_valid (ee_byte_valid),
		.ee_byte       (ee_byte),
		.load          (ee_load),
		.word          (ee_word)
	);

	// ==========================================
	// address decode of the two memory regions
	assign reg_ofs   = {win_addr[11:2], 2'b00};
	assign mem_ofs   = {win_addr[15:2], 2'b00};
	assign hit_regs  = r.mem_en && (win_addr[31:12] == r.bar0_base);  // see RULE_16
	assign hit_mem   = r.mem_en && (win_addr[31:16] == r.bar1_base);  // see RULE_16
	assign cfg_dw    = {cfg_addr[7:2], 2'b00};
	assign vend_area = (cfg_dw >= CFG_VEND_LO);
	assign ram_we    = win_req && win_write && hit_mem && !hit_regs && (mem_ofs < MEM_RAM_TOP);

	// ==========================================
	// next state
	always_comb begin
		logic [31:0] pwr_cs_w;
		logic [31:0] tmp;
		pwr_cs_w = {23'h0, r.pme_en, 6'h0, r.power_state};
		tmp = 32'h0;
		next_r = r;
		next_r.win_ack = 1'b0;
		next_r.cfg_ack = 1'b0;

		// eeprom load first so any host write below overrides it
		if (ee_load) begin
			next_r.preload = ee_word;  // see RULE_09
		end

		// config cycles, byte enables honoured
		if (cfg_req) begin
			next_r.cfg_ack = 1'b1;
			if (!cfg_write) begin
				next_r.cfg_rdata = cfg_view_data;
			end else begin
				tmp = be_merge(cfg_view_data, cfg_wdata, cfg_be);  // see RULE_19
				case (cfg_dw)
					CFG_CMD: begin
						next_r.mem_en = tmp[1];
						next_r.master_en = tmp[2];
					end
					CFG_LAT:  next_r.lat_timer = tmp[LAT_LSB +: 5];
					CFG_BAR0: next_r.bar0_base = tmp[31:12];
					CFG_BAR1: next_r.bar1_base = tmp[31:16];
					CFG_INT:  next_r.int_line = tmp[7:0];
					CFG_PWR_CS: begin
						next_r.pme_en = tmp[PME_EN_BIT];
						next_r.power_state = tmp[1:0];
					end
					// e0h: the guard itself is never locked
					CFG_GUARD: next_r.guard = tmp[15:0];
					// fch: lands only while the guard is open
					CFG_PRELOAD: begin
						if (r.guard_open && vend_area) begin
							next_r.preload = tmp;  // see RULE_03, RULE_17, RULE_20
						end
					end
					default: ;  // 2ch and other read-only words: see RULE_04
				endcase
			end
		end

		// register and memory window cycles
		if (win_req) begin
			next_r.win_ack = 1'b1;
			next_r.win_hit = hit_regs || hit_mem;
			next_r.win_rdata = 32'h0;
			if (hit_regs) begin
				case (reg_ofs)
					// 344h: only pme enable and power state are kept
					WIN_PWR_CS: begin
						tmp = be_merge(pwr_cs_w, win_wdata, win_be);  // see RULE_15
						next_r.win_rdata = pwr_cs_w;
						if (win_write) begin
							next_r.pme_en = tmp[PME_EN_BIT];
							next_r.power_state = tmp[1:0];
						end
					end
					// 3e0h: guard is always writable from the window
					WIN_GUARD: begin
						tmp = be_merge({16'h0, r.guard}, win_wdata, win_be);  // see RULE_14
						next_r.win_rdata = {16'h0, r.guard};
						if (win_write) begin
							next_r.guard = tmp[15:0];
						end
					end
					// 3fch: host path that ignores the guard
					WIN_PRELOAD: begin
						next_r.win_rdata = r.preload;  // see RULE_12
						if (win_write) begin
							next_r.preload = be_merge(r.preload, win_wdata, win_be);  // see RULE_05, RULE_20
						end
					end
					default: begin
						// echo window is read-only; 32ch returns the preload copy
						if (reg_ofs >= WIN_ECHO_LO && reg_ofs <= WIN_ECHO_HI) begin
							next_r.win_rdata = echo_data;  // see RULE_13, RULE_06
						end
					end
				endcase
			end else if (hit_mem && mem_ofs < MEM_RAM_TOP) begin
				next_r.win_rdata = ram[ram_index(mem_ofs)];
			end
		end

		// key compare kept in a flop so guard_open is registered
		next_r.guard_open = (next_r.guard == UNLOCK_KEY);

		// core reset: aux-powered fields keep their contents
		if (reset) begin
			next_r.mem_en = 1'b0;  // see RULE_10
			next_r.master_en = 1'b0;
			next_r.lat_timer = 5'h0;
			next_r.bar0_base = 20'h0;
			next_r.bar1_base = 16'h0;
			next_r.int_line = 8'h0;
			next_r.win_rdata = 32'h0;
			next_r.win_ack = 1'b0;
			next_r.win_hit = 1'b0;
			next_r.cfg_rdata = 32'h0;
			next_r.cfg_ack = 1'b0;
		end
		// aux power-on reset: only place the preload is cleared
		if (aux_reset) begin
			next_r.preload = PRELOAD_RST;  // see RULE_07, RULE_08, RULE_11
			next_r.guard = GUARD_RST;
			next_r.pme_en = 1'b0;
			next_r.power_state = 2'b00;
			next_r.guard_open = (GUARD_RST == UNLOCK_KEY);
		end
	end

	// one state register; both resets live in the next-state logic
	always_ff @(posedge ref_clk) begin
		r <= next_r;
	end

	// memory window ram with byte lanes
	always_ff @(posedge ref_clk) begin
		if (ram_we) begin
			ram[ram_index(mem_ofs)] <= be_merge(ram[ram_index(mem_ofs)], win_wdata, win_be);
		end
	end

	// ==========================================
	// outputs straight from state
	assign win_rdata  = r.win_rdata;
	assign win_ack    = r.win_ack;
	assign win_hit    = r.win_hit;
	assign cfg_rdata  = r.cfg_rdata;
	assign cfg_ack    = r.cfg_ack;
	assign subsys_ids = {r.preload[DEVICE_LSB +: 16], r.preload[VENDOR_LSB +: 16]};  // see RULE_01, RULE_02
	assign guard_open = r.guard_open;
endmodule

//--- ssp_top_props.sv
/*
 * assertions on the top ports of the subsystem id preload block.
 * assumes one clock; eeprom bytes never overlap host writes.
 */
module ssp_top_props
	import ssp_pkg::*;
#(
	parameter logic [15:0] UNLOCK_KEY = 16'h5a5a  // arbitrary value
) (
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic        aux_reset,
	input wire logic        win_req,
	input wire logic        win_write,
	input wire logic [31:0] win_addr,
	input wire logic [3:0]  win_be,
	input wire logic [31:0] win_wdata,
	input wire logic [31:0] win_rdata,
	input wire logic        win_ack,
	input wire logic        win_hit,
	input wire logic        cfg_req,
	input wire logic        cfg_write,
	input wire logic [7:0]  cfg_addr,
	input wire logic [3:0]  cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic        cfg_ack,
	input wire logic        ee_start,
	input wire logic        ee_byte_valid,
	input wire logic [7:0]  ee_byte,
	input wire logic [31:0] subsys_ids,
	input wire logic        guard_open
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// helpers
	logic        ee_d;
	logic        no_ee;
	logic [15:0] wd_lo;
	// eeprom load lands a cycle after its last byte
	always_ff @(posedge ref_clk) begin
		ee_d <= ee_byte_valid;
	end
	assign no_ee = !ee_byte_valid && !ee_d;
	assign wd_lo = win_wdata[15:0];
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset || aux_reset);
	// ==========================================
	// request sequences
	sequence s_cfgw(logic [7:0] a);
		cfg_req && cfg_write && cfg_addr == a && !win_req && no_ee;
	endsequence
	sequence s_winw(logic [11:0] a);
		win_req && win_write && win_addr[11:0] == a && !cfg_req && no_ee;
	endsequence
	sequence s_winr(logic [11:0] a);
		win_req && !win_write && win_addr[11:0] == a && !cfg_req && no_ee;
	endsequence
	// ==========================================
	// properties
	a_cfg_read_2c: assert property (
		cfg_req && !cfg_write && cfg_addr == CFG_SUBSYS && !win_req && no_ee
		|=> cfg_ack && cfg_rdata == subsys_ids)
		else $error("config 2c read differs from preload");
	a_guard_closed: assert property (
		s_cfgw(CFG_PRELOAD) ##0 !guard_open |=> $stable(subsys_ids))
		else $error("locked config write changed preload");
	a_guard_open: assert property (
		s_cfgw(CFG_PRELOAD) ##0 (guard_open && cfg_be == 4'hf) |=> subsys_ids == $past(cfg_wdata))
		else $error("unlocked config write not taken");
	a_win_ungated: assert property (
		s_winw(WIN_PRELOAD) ##0 win_be == 4'hf ##1 win_hit |-> subsys_ids == $past(win_wdata))
		else $error("window preload write not taken");
	a_copy_read: assert property (
		s_winr(WIN_RO_COPY) ##1 win_hit |-> win_rdata == subsys_ids)
		else $error("window copy differs from preload");
	a_echo_ro: assert property (
		s_winw(WIN_RO_COPY) |=> $stable(subsys_ids))
		else $error("echo write changed preload");
	a_core_keep: assert property (disable iff (aux_reset)
		reset && !win_req && !cfg_req && no_ee |=> $stable(subsys_ids))
		else $error("core reset changed preload");
	a_aux_clear: assert property (disable iff (1'b0)
		aux_reset |=> subsys_ids == 32'h0 && !guard_open)
		else $error("aux reset did not clear preload");
	a_win_answer: assert property (
		win_ack == $past(win_req))
		else $error("window answer not one cycle late");
	a_guard_win: assert property (
		s_winw(WIN_GUARD) ##0 win_be == 4'hf ##1 win_hit |-> guard_open == ($past(wd_lo) == UNLOCK_KEY))
		else $error("window guard write wrong");
endmodule

//--- ssp_host_model.sv
/*
 * host bridge model: config and window cycles, eeprom byte feed.
 * assumes the block answers exactly one cycle after each request.
 */
module ssp_host_model (
	input  wire logic        ref_clk,
	output logic             win_req,
	output logic             win_write,
	output logic      [31:0] win_addr,
	output logic      [3:0]  win_be,
	output logic      [31:0] win_wdata,
	input  wire logic [31:0] win_rdata,
	input  wire logic        win_ack,
	input  wire logic        win_hit,
	output logic             cfg_req,
	output logic             cfg_write,
	output logic      [7:0]  cfg_addr,
	output logic      [3:0]  cfg_be,
	output logic      [31:0] cfg_wdata,
	input  wire logic [31:0] cfg_rdata,
	input  wire logic        cfg_ack,
	output logic             ee_start,
	output logic             ee_byte_valid,
	output logic      [7:0]  ee_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial begin
		{win_req, win_write, cfg_req, cfg_write, ee_start, ee_byte_valid} = 6'h0;
		{win_addr, win_wdata, cfg_wdata} = 96'h0;
		{win_be, cfg_be, cfg_addr, ee_byte} = 24'h0;
	end
	// one data phase, lanes as be gives; lines scrambled after release
	task automatic xfer(input logic iw, input logic w, input logic [31:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic [31:0] q, output logic ok);
		@(posedge ref_clk);
		if (iw) begin
			{win_req, win_write, win_addr, win_be, win_wdata} <= {1'b1, w, a, be, d};
		end else begin
			{cfg_req, cfg_write, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, w, a[7:0], be, d};
		end
		@(posedge ref_clk);
		{win_req, cfg_req} <= 2'h0;
		{win_addr, win_wdata, cfg_addr, cfg_wdata} <= {~a, ~d, ~a[7:0], ~d};
		#1;
		q = iw ? win_rdata : cfg_rdata;
		ok = iw ? (win_ack & win_hit) : cfg_ack;
	endtask
	// eeprom stream after a start, byte 0 first
	task automatic ee_load(input logic [39:0] s);
		@(posedge ref_clk) ee_start <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			@(posedge ref_clk) {ee_start, ee_byte_valid, ee_byte} <= {2'b01, s[i*8 +: 8]};
			@(posedge ref_clk) {ee_byte_valid, ee_byte} <= {1'b0, ~s[i*8 +: 8]};
		end
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
endmodule

//--- testbench.sv
/*
 * self-checking bench of the subsystem id preload block.
 * assumes the host model drives every bus cycle; one 100 MHz clock.
 */
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench
	import ssp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] KEY  = 16'h5a5a;        // arbitrary value
	localparam logic [15:0] VC   = 16'h0f0f;        // arbitrary value
	localparam logic [15:0] DC   = 16'h0e0e;        // arbitrary value
	localparam logic [31:0] BAR0 = 32'h1000_0000;
	localparam logic [31:0] BAR1 = 32'h2000_0000;
	logic        ref_clk = 1'b0;
	logic        reset, aux_reset, win_req, win_write, cfg_req, cfg_write, ok;
	logic        win_ack, win_hit, cfg_ack, ee_start, ee_byte_valid, guard_open;
	logic [31:0] win_addr, win_wdata, win_rdata, cfg_wdata, cfg_rdata, subsys_ids, q;
	logic [3:0]  win_be, cfg_be;
	logic [7:0]  cfg_addr, ee_byte;
	int          err_count = 0;
	int          checks = 0;
	// ==========================================
	// clock, block and host
	always #5 ref_clk = ~ref_clk;
	ssp_top #(.UNLOCK_KEY(KEY), .VENDOR_CODE(VC), .DEVICE_CODE(DC)) uut (.*);
	ssp_host_model host (.*);
	// ==========================================
	// access helpers
	task automatic rd(input logic iw, input logic [31:0] a);
		host.xfer(iw, 1'b0, a, 4'hf, 32'h0, q, ok);
	endtask
	task automatic wr(input logic iw, input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
		host.xfer(iw, 1'b1, a, be, d, q, ok);
	endtask
	// ==========================================
	// scenarios
	task automatic t_setup;
		wr(0, CFG_CMD, 4'h1, 32'h6);
		wr(0, CFG_BAR0, 4'hf, BAR0);
		wr(0, CFG_BAR1, 4'hf, BAR1);
		rd(0, CFG_BAR0);
		`CHK(q, BAR0)
		rd(0, CFG_SUBSYS);
		`CHK(q, PRELOAD_RST)
		rd(1, BAR0 | WIN_GUARD);
		`CHK(q, {16'h0, GUARD_RST})
		wr(0, CFG_INT, 4'h1, 32'hffff_ffa5);
		rd(0, CFG_INT);
		`CHK(q, {MAX_LAT, MIN_GNT, INT_PIN, 8'ha5})
	endtask
	task automatic t_guard;
		wr(0, CFG_PRELOAD, 4'hf, 32'h1111_2222);
		`CHK(subsys_ids, 32'h0)
		wr(0, CFG_GUARD, 4'h3, {16'hffff, KEY});
		`CHK(guard_open, 1'b1)
		wr(0, CFG_PRELOAD, 4'hf, 32'habcd_1234);
		rd(0, CFG_SUBSYS);
		`CHK(q, 32'habcd_1234)
		`CHK(subsys_ids[15:0], 16'h1234)
		`CHK(subsys_ids[31:16], 16'habcd)
		wr(0, CFG_PRELOAD, 4'h2, 32'h0000_5600);
		`CHK(subsys_ids, 32'habcd_5634)
		wr(0, CFG_SUBSYS, 4'hf, 32'h0);
		`CHK(subsys_ids, 32'habcd_5634)
		wr(0, CFG_GUARD, 4'h3, 32'h0);
		`CHK(guard_open, 1'b0)
	endtask
	task automatic t_window;
		wr(1, BAR0 | WIN_PRELOAD, 4'hf, 32'h0c0d_0e0f);
		`CHK(subsys_ids, 32'h0c0d_0e0f)
		rd(1, BAR0 | WIN_RO_COPY);
		`CHK(q, 32'h0c0d_0e0f)
		`CHK(ok, 1'b1)
		wr(1, BAR0 | WIN_RO_COPY, 4'hf, 32'h0);
		`CHK(subsys_ids, 32'h0c0d_0e0f)
		rd(1, BAR0 | WIN_ECHO_LO);
		`CHK(q, {DC, VC})
		wr(1, BAR0 | WIN_GUARD, 4'hf, {16'h0, KEY});
		`CHK(guard_open, 1'b1)
		wr(1, BAR0 | WIN_GUARD, 4'hf, 32'h0);
		wr(1, BAR0 | WIN_PWR_CS, 4'hf, 32'h0000_0103);
		rd(1, BAR0 | WIN_PWR_CS);
		`CHK(q, 32'h0000_0103)
		rd(1, BAR0 | 32'h800);
		`CHK(q, 32'h0)
		wr(1, BAR1 | 32'h10, 4'hf, 32'h5a5a_a5a5);
		rd(1, BAR1 | 32'h10);
		`CHK(q, 32'h5a5a_a5a5)
		rd(1, 32'h3000_0000);
		`CHK(ok, 1'b0)
	endtask
	task automatic t_eeprom;
		host.ee_load({32'h4433_2211, EE_MARKER});
		`CHK(subsys_ids, 32'h4433_2211)
		host.ee_load({32'h8877_6655, 8'h54});
		`CHK(subsys_ids, 32'h4433_2211)
	endtask
	task automatic t_resets;
		wr(0, CFG_GUARD, 4'h3, {16'h0, KEY});
		@(posedge ref_clk) reset <= 1'b1;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1;
		`CHK(subsys_ids, 32'h4433_2211)
		`CHK(guard_open, 1'b1)
		rd(0, CFG_INT);
		`CHK(q, {MAX_LAT, MIN_GNT, INT_PIN, 8'h00})
		rd(1, BAR0 | WIN_PRELOAD);
		`CHK(ok, 1'b0)
		@(posedge ref_clk) aux_reset <= 1'b1;
		@(posedge ref_clk) aux_reset <= 1'b0;
		@(posedge ref_clk);
		#1;
		`CHK(subsys_ids, PRELOAD_RST)
		`CHK(guard_open, 1'b0)
	endtask
	// ==========================================
	// verdict and main sequence
	task automatic give_verdict;
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		{reset, aux_reset} <= 2'b11;
		repeat (3) @(posedge ref_clk);
		{reset, aux_reset} <= 2'b00;
		@(posedge ref_clk);
		t_setup();
		t_guard();
		t_window();
		t_eeprom();
		t_resets();
		give_verdict();
	end
	// watchdog far beyond the hundred or so cycles needed
	initial begin
		#100us;
		err_count++;
		give_verdict();
	end
endmodule
bind ssp_top ssp_top_props #(.UNLOCK_KEY(UNLOCK_KEY)) chk (.*);
